// [common_command_status_unit.sv]
// Common command interpreter with event status, status byte and configuration slots.
//
// Behaviour
// [RL1] Clear-status zeroes the event register and pulses clear to outside summaries.
// [RL2] Event enable write stores a mask; one enables the matching event bit.
// [RL3] Event enable parameter 0 to 255 maps straight onto eight mask bits.
// [RL4] Event enable query returns the stored mask unchanged.
// [RL5] Event status query returns the value then clears the register.
// [RL6] Event bits: 0 opc, 2 query, 3 device, 4 exec, 5 command, 7 power.
// [RL7] After opc command, bit 0 sets only once pending operations finish.
// [RL8] Opc query answers 1 once all operations have finished.
// [RL9] Identify query returns five comma-separated fields.
// [RL10] Options query reports options, empty string when none installed.
// [RL11] Recall restores configuration from slot 0 to 9.
// [RL12] Recall of an empty slot flags error 115.
// [RL13] Reset command returns configuration to its power-up state.
// [RL14] Save accepts only slot 0 to 9, same slots as recall.
// [RL15] Service enable write stores bits 0 to 5 and 7; bit 6 stays zero.
// [RL16] Service enable bits: 1 device, 2 error queue, 3 questionable, 4 message, 5 event, 7 operation.
// [RL17] Service enable query returns the mask with bit 6 zero.
// [RL18] Status byte query puts master summary in bit 6.
// [RL19] Status bit 1 shows device condition, bit 2 non-empty error queue.
// [RL20] Status bit 4 shows an output message ready.
// [RL21] Status bit 3 questionable, bit 7 operation, bit 5 event summary.
// [RL22] Trigger fires only while waiting; otherwise ignored with error 210.
// [RL23] Output buffer empties after power-up, reset and system preset.
// [RL24] Status bit 5 is OR of event register AND event enable.
// [RL25] Event bits latch until read or clear-status.
`timescale 1ns/1ns
module common_command_status_unit
  import ccsu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire cmd_t cmd,
  input wire logic cmdValid,
  output logic cmdReady,
  output rsp_t rsp,
  output logic rspValid,
  input wire logic [7:0] evtIn,
  input wire logic opsBusy,
  input wire logic waitTrigger,
  input wire logic devCondition,
  input wire logic errQueueNotEmpty,
  input wire logic questCondition,
  input wire logic operCondition,
  input wire logic outMsgReady,
  input wire logic sysPreset,
  input wire logic [7:0] optionsInstalled,
  input wire logic cfgWrite,
  input wire logic [CFG_W-1:0] cfgWriteData,
  output logic [CFG_W-1:0] cfgState,
  output logic trigFire,
  output logic statusClear,
  output logic outBufClear,
  output logic errPush,
  output logic [7:0] errCode
);

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IDN = 2'b01,
    ST_OPCQ = 2'b10
  } state_t;

  state_t state;
  logic take;
  logic [7:0] esr;
  logic [7:0] ese;
  logic [7:0] sre;
  logic [7:0] stb;
  logic opcArmed;
  logic opcSet;
  logic [3:0] idnIdx;
  logic [CFG_W-1:0] slots [SLOT_COUNT];
  logic [9:0] slotValid;
  logic slotInRange;
  logic recallEmpty;
  logic trigIgnored;
  logic [7:0] next_esrSet;
  logic [7:0] idnByte;

  assign cmdReady = (state == ST_IDLE);
  assign take = cmdValid && cmdReady;
  assign slotInRange = (cmd.arg <= SLOT_MAX);
  assign recallEmpty = take && cmd.code == CMD_RCL && slotInRange && !slotValid[cmd.arg[3:0]];
  assign trigIgnored = take && cmd.code == CMD_TRG && !waitTrigger;

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  always_comb begin
    stb = 8'h00;
    stb[STB_DEV] = devCondition; // see [RL19]
    stb[STB_QUEUE] = errQueueNotEmpty; // see [RL19]
    stb[STB_QUEST] = questCondition; // see [RL21]
    stb[STB_MAV] = outMsgReady; // see [RL20]
    stb[STB_ESB] = |(esr & ese); // see [RL24] [RL21]
    stb[STB_OPER] = operCondition; // see [RL21]
    stb[STB_MSS] = |(stb & sre & SRE_STORED); // see [RL18]
  end

  // ----------------------------------------
  // Standard event status
  // ----------------------------------------
  always_comb begin
    next_esrSet = evtIn & EVT_EXT; // see [RL6]
    next_esrSet[EVT_OPC] = opcSet; // see [RL7]
    if (recallEmpty || trigIgnored) begin
      next_esrSet[EVT_EXEC] = 1'b1;
    end
    if (take && (cmd.code == CMD_RCL || cmd.code == CMD_SAV) && !slotInRange) begin
      next_esrSet[EVT_EXEC] = 1'b1;
    end
  end

  // A new event in the cycle of a read or clear survives; it shows on the next read.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      esr <= ESR_RESET;
    end else if (take && (cmd.code == CMD_CLS || cmd.code == CMD_ESR_Q)) begin
      esr <= next_esrSet & EVT_USED; // see [RL1] [RL5] [RL25]
    end else begin
      esr <= (esr | next_esrSet) & EVT_USED; // see [RL25]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ese <= ESE_RESET;
    end else if (take && cmd.code == CMD_ESE) begin
      ese <= cmd.arg; // see [RL2] [RL3]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sre <= SRE_RESET;
    end else if (take && cmd.code == CMD_SRE) begin
      sre <= cmd.arg & SRE_STORED; // see [RL15] [RL16]
    end
  end

  // ----------------------------------------
  // Operation complete
  // ----------------------------------------
  assign opcSet = opcArmed && !opsBusy;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opcArmed <= 1'b0;
    end else if (take && cmd.code == CMD_OPC) begin
      opcArmed <= 1'b1; // see [RL7]
    end else if (opcSet || (take && cmd.code == CMD_CLS)) begin
      opcArmed <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration slots
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgState <= CFG_POWERUP;
    end else if (take && cmd.code == CMD_RST) begin
      cfgState <= CFG_POWERUP; // see [RL13]
    end else if (take && cmd.code == CMD_RCL && slotInRange && slotValid[cmd.arg[3:0]]) begin
      cfgState <= slots[cmd.arg[3:0]]; // see [RL11]
    end else if (cfgWrite) begin
      cfgState <= cfgWriteData;
    end
  end

  // Slot contents need no reset; the valid bits guard every read of them.
  always_ff @(posedge ref_clk) begin
    if (take && cmd.code == CMD_SAV && slotInRange) begin
      slots[cmd.arg[3:0]] <= cfgState; // see [RL14]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slotValid <= SLOT_VALID_RESET;
    end else if (take && cmd.code == CMD_SAV && slotInRange) begin
      slotValid[cmd.arg[3:0]] <= 1'b1; // see [RL14]
    end
  end

  // ----------------------------------------
  // Errors, trigger and clears
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      errPush <= 1'b0;
      errCode <= 8'h00;
    end else begin
      errPush <= 1'b0;
      if (recallEmpty) begin
        errPush <= 1'b1;
        errCode <= ERR_NO_SAVED; // see [RL12]
      end else if (trigIgnored) begin
        errPush <= 1'b1;
        errCode <= ERR_TRIGGER; // see [RL22]
      end else if (take && (cmd.code == CMD_RCL || cmd.code == CMD_SAV) && !slotInRange) begin
        errPush <= 1'b1;
        errCode <= ERR_RANGE; // see [RL14]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigFire <= 1'b0;
    end else begin
      trigFire <= take && cmd.code == CMD_TRG && waitTrigger; // see [RL22]
    end
  end

  // The clear pulse is also raised out of reset so the buffer starts empty.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outBufClear <= 1'b1;
      statusClear <= 1'b0;
    end else begin
      outBufClear <= (take && cmd.code == CMD_RST) || sysPreset; // see [RL23]
      statusClear <= take && cmd.code == CMD_CLS; // see [RL1]
    end
  end

  // ----------------------------------------
  // Responses
  // ----------------------------------------
  always_comb begin
    case (idnIdx)
      4'h0: idnByte = ID_MAKER;
      4'h2: idnByte = ID_PRODUCT;
      4'h4: idnByte = ID_SERIAL;
      4'h6: idnByte = ID_FIRMWARE;
      4'h8: idnByte = ID_DEVICE;
      default: idnByte = ID_COMMA;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      idnIdx <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          idnIdx <= 4'h0;
          if (take && cmd.code == CMD_IDN_Q) begin
            state <= ST_IDN;
          end else if (take && cmd.code == CMD_OPC_Q) begin
            state <= ST_OPCQ;
          end
        end
        ST_IDN: begin
          idnIdx <= idnIdx + 4'h1;
          if (idnIdx == ID_LAST_IDX) begin
            state <= ST_IDLE;
          end
        end
        ST_OPCQ: begin
          if (!opsBusy) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rspValid <= 1'b0;
      rsp <= '0;
    end else begin
      rspValid <= 1'b0;
      rsp <= '{data: 8'h00, last: 1'b1, empty: 1'b0};
      if (state == ST_IDN) begin
        rspValid <= 1'b1;
        rsp <= '{data: idnByte, last: idnIdx == ID_LAST_IDX, empty: 1'b0}; // see [RL9]
      end else if (state == ST_OPCQ && !opsBusy) begin
        rspValid <= 1'b1;
        rsp.data <= 8'h01; // see [RL8]
      end else if (take) begin
        case (cmd.code)
          CMD_ESE_Q: begin
            rspValid <= 1'b1;
            rsp.data <= ese; // see [RL4]
          end
          CMD_ESR_Q: begin
            rspValid <= 1'b1;
            rsp.data <= esr; // see [RL5]
          end
          CMD_SRE_Q: begin
            rspValid <= 1'b1;
            rsp.data <= sre & SRE_STORED; // see [RL17]
          end
          CMD_STB_Q: begin
            rspValid <= 1'b1;
            rsp.data <= stb; // see [RL18]
          end
          CMD_OPT_Q: begin
            rspValid <= 1'b1;
            rsp.data <= optionsInstalled;
            rsp.empty <= (optionsInstalled == 8'h00); // see [RL10]
          end
          default: rspValid <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_CLS_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL1]
    take && cmd.code == CMD_CLS && next_esrSet == 8'h00 |=> esr == 8'h00 && statusClear)
    else $error("Clear-status left event bits set.");

  AST_ESE_STORE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL2]
    take && cmd.code == CMD_ESE |=> ese == $past(cmd.arg))
    else $error("Event enable not stored.");

  AST_ESE_READ: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL4]
    take && cmd.code == CMD_ESE_Q |=> rspValid && rsp.data == ese)
    else $error("Event enable query wrong.");

  AST_ESR_READCLR: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL5]
    take && cmd.code == CMD_ESR_Q && next_esrSet == 8'h00 |=>
    rspValid && rsp.data == $past(esr) && esr == 8'h00)
    else $error("Event status read did not clear.");

  AST_ESR_UNUSED: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL6]
    esr[1] == 1'b0 && esr[6] == 1'b0)
    else $error("Unused event bit set.");

  AST_OPC_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL7]
    opcArmed && opsBusy |=> !$rose(esr[EVT_OPC]) || !$past(opsBusy))
    else $error("Operation complete set while busy.");

  AST_OPCQ_ONE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL8]
    state == ST_OPCQ && !opsBusy |=> rspValid && rsp.data == 8'h01 && state == ST_IDLE)
    else $error("Operation complete query answer wrong.");

  AST_IDN_LEN: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL9]
    take && cmd.code == CMD_IDN_Q |=> ##1 rspValid [*8] ##1 rspValid && rsp.last)
    else $error("Identify stream not nine bytes.");

  AST_RCL_EMPTY: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL12]
    recallEmpty |=> errPush && errCode == ERR_NO_SAVED && $stable(cfgState))
    else $error("Empty recall not flagged.");

  AST_RST_CFG: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL13]
    take && cmd.code == CMD_RST |=> cfgState == CFG_POWERUP && outBufClear)
    else $error("Reset did not restore power-up state.");

  AST_SRE_BIT6: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL15]
    take && cmd.code == CMD_SRE |=> sre == ($past(cmd.arg) & 8'hBF))
    else $error("Service enable stored wrong.");

  AST_MSS: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL18]
    take && cmd.code == CMD_STB_Q && (stb & sre & 8'hBF) != 8'h00 |=> rsp.data[6])
    else $error("Master summary missing.");

  AST_ESB: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL24]
    stb[STB_ESB] == |(esr & ese))
    else $error("Event summary wrong.");

  AST_TRG_IGNORE: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RL22]
    trigIgnored |=> !trigFire && errPush && errCode == ERR_TRIGGER)
    else $error("Ignored trigger not flagged.");

endmodule

// [ccsu_pkg.sv]
// Package with command codes, status bit positions, reset values and carrier types.
package ccsu_pkg;

  // ----------------------------------------
  // Commands
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_CLS   = 4'h0,
    CMD_ESE   = 4'h1,
    CMD_ESE_Q = 4'h2,
    CMD_ESR_Q = 4'h3,
    CMD_IDN_Q = 4'h4,
    CMD_OPC   = 4'h5,
    CMD_OPC_Q = 4'h6,
    CMD_OPT_Q = 4'h7,
    CMD_RCL   = 4'h8,
    CMD_RST   = 4'h9,
    CMD_SAV   = 4'hA,
    CMD_SRE   = 4'hB,
    CMD_SRE_Q = 4'hC,
    CMD_STB_Q = 4'hD,
    CMD_TRG   = 4'hE
  } cmd_code_t;

  typedef struct packed {
    cmd_code_t code;
    logic [7:0] arg;
  } cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic empty;
  } rsp_t;

  // ----------------------------------------
  // Status layout
  // ----------------------------------------
  localparam int EVT_OPC = 0;
  localparam int EVT_QUERY = 2;
  localparam int EVT_DEVICE = 3;
  localparam int EVT_EXEC = 4;
  localparam int EVT_COMMAND = 5;
  localparam int EVT_POWER = 7;
  localparam logic [7:0] EVT_USED = 8'hBD;
  localparam logic [7:0] EVT_EXT = 8'h3C;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam int STB_DEV = 1;
  localparam int STB_QUEUE = 2;
  localparam int STB_QUEST = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;
  localparam int STB_OPER = 7;
  localparam logic [7:0] SRE_STORED = 8'hBF;
  localparam logic [7:0] SRE_RESET = 8'h00;

  // ----------------------------------------
  // Configuration slots and errors
  // ----------------------------------------
  localparam int CFG_W = 16;
  localparam int SLOT_COUNT = 10;
  localparam logic [7:0] SLOT_MAX = 8'h09;
  localparam logic [CFG_W-1:0] CFG_POWERUP = 16'h0000;
  localparam logic [9:0] SLOT_VALID_RESET = 10'h000;
  localparam logic [7:0] ERR_NO_SAVED = 8'd115;
  localparam logic [7:0] ERR_TRIGGER = 8'd210;
  localparam logic [7:0] ERR_RANGE = 8'd222;

  // ----------------------------------------
  // Identification, values are arbitrary
  // ----------------------------------------
  localparam logic [7:0] ID_MAKER = 8'h4D;
  localparam logic [7:0] ID_PRODUCT = 8'h50;
  localparam logic [7:0] ID_SERIAL = 8'h31;
  localparam logic [7:0] ID_FIRMWARE = 8'h46;
  localparam logic [7:0] ID_DEVICE = 8'h44;
  localparam logic [7:0] ID_COMMA = 8'h2C;
  localparam logic [3:0] ID_LAST_IDX = 4'h8;

endpackage

// [host_link_model.sv]
// Host-side command model that issues requests and collects response bytes.
`timescale 1ns/1ns
module host_link_model
  import ccsu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic cmdReady,
  input wire rsp_t rsp,
  input wire logic rspValid,
  output cmd_t cmd,
  output logic cmdValid
);
  rsp_t rxq[$];
  logic readyLate;

  initial begin
    cmd = '0;
    cmdValid = 1'b0;
  end

  // Ready is sampled mid-cycle so the take decision never races the edge.
  always @(negedge ref_clk) begin
    readyLate = cmdReady;
  end

  always @(posedge ref_clk) begin
    if (rspValid === 1'b1) begin
      rxq.push_back(rsp);
    end
  end

  // Callers keep arguments in range except where a refusal is the point.
  task automatic issue(input cmd_code_t code, input logic [7:0] arg);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd <= '{code: code, arg: arg};
    cmdValid <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (readyLate !== 1'b1 && n < 200);
    cmdValid <= 1'b0;
    // Released lines show the inverse so stale values are never mistaken for a request.
    cmd <= cmd_t'(~{code, arg});
  endtask
endmodule

// [tb.sv]
// Self-checking testbench for the common command and status unit.
`timescale 1ns/1ns
module tb;
  import ccsu_pkg::*;
  logic ref_clk, sys_rst, cmdValid, cmdReady, rspValid;
  logic opsBusy, waitTrigger, sysPreset, cfgWrite, trigFire, statusClear, outBufClear, errPush;
  cmd_t cmd;
  rsp_t rsp, got;
  logic [7:0] evtIn, optionsInstalled, errCode;
  logic [4:0] stsIn;
  logic [CFG_W-1:0] cfgWriteData, cfgState;
  int miscompares, compares, nTrig, nStatClr, nOutClr, nErr, base;
  logic [7:0] vals [4] = '{8'h00, 8'hA5, 8'hFF, 8'h3C};
  logic [7:0] sres [2] = '{8'h00, 8'h9E};
  logic [7:0] idBytes [9] = '{ID_MAKER, ID_COMMA, ID_PRODUCT, ID_COMMA, ID_SERIAL, ID_COMMA,
    ID_FIRMWARE, ID_COMMA, ID_DEVICE};

  common_command_status_unit uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd(cmd),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .rsp(rsp), .rspValid(rspValid),
    .evtIn(evtIn), .opsBusy(opsBusy), .waitTrigger(waitTrigger), .devCondition(stsIn[0]),
    .errQueueNotEmpty(stsIn[1]), .questCondition(stsIn[2]), .operCondition(stsIn[3]),
    .outMsgReady(stsIn[4]), .sysPreset(sysPreset), .optionsInstalled(optionsInstalled),
    .cfgWrite(cfgWrite), .cfgWriteData(cfgWriteData), .cfgState(cfgState),
    .trigFire(trigFire), .statusClear(statusClear), .outBufClear(outBufClear),
    .errPush(errPush), .errCode(errCode));
  host_link_model host (.ref_clk(ref_clk), .cmdReady(cmdReady), .rsp(rsp),
    .rspValid(rspValid), .cmd(cmd), .cmdValid(cmdValid));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    nTrig <= nTrig + int'(trigFire === 1'b1);
    nStatClr <= nStatClr + int'(statusClear === 1'b1);
    nOutClr <= nOutClr + int'(outBufClear === 1'b1);
    nErr <= nErr + int'(errPush === 1'b1);
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] stbExp(input logic [4:0] s, input logic esb, input logic [7:0] m);
    logic [7:0] b;
    b = {s[3], 1'b0, esb, s[4], s[2], s[1], s[0], 1'b0};
    return b | {1'b0, |(b & m & 8'hBF), 6'b0};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic waitRsp(input int count);
    int n;
    n = 0;
    while (host.rxq.size() < count && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    chk("response count", 16'(count), 16'(host.rxq.size()));
    got = (host.rxq.size() > 0) ? host.rxq[0] : '0;
  endtask

  task automatic ask(input cmd_code_t code, input logic [7:0] arg, input logic [7:0] exp);
    host.rxq.delete();
    host.issue(code, arg);
    waitRsp(1);
    chk("response data", 16'(exp), 16'(got.data));
    chk("response last", 16'h0001, 16'(got.last));
  endtask

  task automatic cmdDo(input cmd_code_t code, input logic [7:0] arg);
    host.issue(code, arg);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic evt(input logic [7:0] v);
    @(posedge ref_clk);
    evtIn <= v;
    @(posedge ref_clk);
    evtIn <= 8'h00;
  endtask

  task automatic cfgPut(input logic [CFG_W-1:0] v);
    @(posedge ref_clk);
    cfgWrite <= 1'b1;
    cfgWriteData <= v;
    @(posedge ref_clk);
    cfgWrite <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // The sequence needs well under two thousand cycles; ten times that means a hang.
  initial begin
    #(20000 * 4);
    miscompares++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {sys_rst, opsBusy, waitTrigger, sysPreset, cfgWrite} = 5'b10000;
    {evtIn, optionsInstalled, stsIn, cfgWriteData} = '0;
    {miscompares, compares, nTrig, nStatClr, nOutClr, nErr} = '0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    ask(CMD_ESR_Q, 8'h00, 8'h80);
    ask(CMD_ESR_Q, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cmdDo(CMD_ESE, vals[i]);
      ask(CMD_ESE_Q, 8'h00, vals[i]);
      cmdDo(CMD_SRE, vals[i]);
      ask(CMD_SRE_Q, 8'h00, vals[i] & SRE_STORED);
    end
    evt(8'h3C);
    ask(CMD_STB_Q, 8'h00, stbExp(5'h00, 1'b1, 8'h3C));
    ask(CMD_ESR_Q, 8'h00, 8'h3C);
    ask(CMD_STB_Q, 8'h00, stbExp(5'h00, 1'b0, 8'h3C));
    for (int k = 0; k < 2; k++) begin
      cmdDo(CMD_SRE, sres[k]);
      for (int i = 0; i < 5; i++) begin
        stsIn <= 5'(1 << i);
        ask(CMD_STB_Q, 8'h00, stbExp(5'(1 << i), 1'b0, sres[k]));
      end
      stsIn <= 5'h00;
    end
    evt(8'h04);
    base = nStatClr;
    cmdDo(CMD_CLS, 8'h00);
    chk("status clear pulses", 16'(base + 1), 16'(nStatClr));
    ask(CMD_ESR_Q, 8'h00, 8'h00);
    opsBusy <= 1'b1;
    cmdDo(CMD_OPC, 8'h00);
    repeat (5) @(posedge ref_clk);
    ask(CMD_ESR_Q, 8'h00, 8'h00);
    opsBusy <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ask(CMD_ESR_Q, 8'h00, 8'h01);
    opsBusy <= 1'b1;
    host.rxq.delete();
    host.issue(CMD_OPC_Q, 8'h00);
    repeat (6) @(posedge ref_clk);
    chk("early answer", 16'h0000, 16'(host.rxq.size()));
    opsBusy <= 1'b0;
    waitRsp(1);
    chk("opc answer", 16'h0001, 16'(got.data));
    host.rxq.delete();
    host.issue(CMD_IDN_Q, 8'h00);
    waitRsp(9);
    for (int i = 0; i < 9; i++) begin
      got = (host.rxq.size() > i) ? host.rxq[i] : '0;
      chk("identify byte", 16'({idBytes[i], i == 8}), 16'({got.data, got.last}));
    end
    host.rxq.delete();
    host.issue(CMD_OPT_Q, 8'h00);
    waitRsp(1);
    chk("options empty", 16'h0001, 16'(got.empty));
    optionsInstalled <= 8'h05;
    ask(CMD_OPT_Q, 8'h00, 8'h05);
    chk("options empty", 16'h0000, 16'(got.empty));
    cfgPut(16'h1234);
    cmdDo(CMD_SAV, SLOT_MAX);
    cfgPut(16'h5678);
    cmdDo(CMD_RCL, SLOT_MAX);
    chk("recalled config", 16'h1234, cfgState);
    base = nErr;
    cmdDo(CMD_RCL, 8'h00);
    chk("error code", 16'(ERR_NO_SAVED), 16'(errCode));
    chk("error pushes", 16'(base + 1), 16'(nErr));
    cmdDo(CMD_SAV, 8'h0A);
    chk("error code", 16'(ERR_RANGE), 16'(errCode));
    cmdDo(CMD_RCL, 8'h0A);
    chk("error code", 16'(ERR_RANGE), 16'(errCode));
    chk("config kept", 16'h1234, cfgState);
    ask(CMD_ESR_Q, 8'h00, 8'h10);
    base = nOutClr;
    cmdDo(CMD_RST, 8'h00);
    chk("reset config", 16'(CFG_POWERUP), cfgState);
    chk("buffer clears", 16'(base + 1), 16'(nOutClr));
    @(posedge ref_clk);
    sysPreset <= 1'b1;
    @(posedge ref_clk);
    sysPreset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("buffer clears", 16'(base + 2), 16'(nOutClr));
    base = nTrig;
    cmdDo(CMD_TRG, 8'h00);
    chk("trigger ignored", 16'(base), 16'(nTrig));
    chk("error code", 16'(ERR_TRIGGER), 16'(errCode));
    waitTrigger <= 1'b1;
    cmdDo(CMD_TRG, 8'h00);
    chk("trigger fired", 16'(base + 1), 16'(nTrig));
    ask(CMD_ESR_Q, 8'h00, 8'h10);
    wrap_up();
  end
endmodule
